//--- common/clock_buffer_regs_pkg.sv
package clock_buffer_regs_pkg;

	// Register indices
	localparam logic [6:0] REG_FREQ_PLL_MODE_CONTROL = 7'h00;
	localparam logic [6:0] REG_OUTPUT_ENABLE_LOW     = 7'h01;
	localparam logic [6:0] REG_OUTPUT_ENABLE_HIGH    = 7'h02;
	localparam logic [6:0] REG_RESERVED_CONTROL_A    = 7'h03;
	localparam logic [6:0] REG_RESERVED_CONTROL_B    = 7'h04;
	localparam logic [6:0] REG_VENDOR_REVISION       = 7'h05;
	localparam logic [6:0] REG_DEVICE_IDENT          = 7'h06;
	localparam logic [6:0] REG_READBACK_COUNT        = 7'h07;

	// Byte 0 and command byte field positions
	localparam int FREQ_SELECT_BIT = 0;
	localparam int PLL_SW_ENABLE   = 2;   // Within the 3-bit control field (byte 0 bit 3)
	localparam int CMD_BYTE_MODE   = 7;   // Command bit: set means single byte

	// Reset values
	localparam logic [2:0] CTRL_RESET         = 3'h3;
	localparam logic [7:0] OUTPUT_EN_RESET    = 8'hFF;
	localparam logic [4:0] READBACK_CNT_RESET = 5'h08;
	localparam logic [7:0] BYTE_ZERO          = 8'h00;

	// Bus framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT      = 4'h7;
	localparam logic [6:0] SLAVE_ADDRESS = 7'h6C;
	localparam logic [5:0] BYTE_MODE_CNT = 6'h01;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RECV = 5'b00010,
		ST_RACK = 5'b00100,
		ST_SEND = 5'b01000,
		ST_MACK = 5'b10000
	} fsm_type;

	typedef enum logic [3:0] {
		PH_ADDR  = 4'b0001,
		PH_CMD   = 4'b0010,
		PH_COUNT = 4'b0100,
		PH_DATA  = 4'b1000
	} phase_type;

	typedef struct packed {
		fsm_type    fsm;
		phase_type  phase;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [6:0] index;
		logic       read;
		logic       block;
		logic       countSent;
		logic [5:0] remain;
		logic       sclPrev;
		logic       sdaPrev;
		logic       pgPrev;
		logic       latched;
		logic       freqStrap;
		logic [1:0] pllStrap;
		logic [2:0] ctrl;
		logic [7:0] oe;
		logic [4:0] rbCount;
		logic       sdaOe;
		logic       sdaLevel;
		logic [7:0] diffEn;
		logic [1:0] pllMode;
	} state_type;

endpackage

//--- logic/clock_buffer_smbus_regs.sv
`timescale 1ns/1ps
// Contract
// - In power-down, release the bus data line and keep all register contents.
// - Command bit 7 set means single byte; clear means block with count.
// - Byte read: repeated start, device sends, host acks all but last, then stop.
// - Block read: index acked, after repeated start count byte goes first.
// - Block write starts at command byte low seven bits.
// - Block command zero starts at register zero.
// - Block write: count then data, every byte acked, host stops.
// - Byte 0 bit 0 is read-only power-up frequency select.
// - Byte 0 bit 3 selects strap or bits 2:1 as PLL mode.
// - Byte 0 bits 7:6 always read the latched strap PLL mode.
// - Byte 1 holds enables for outputs 0 to 5; bits 0,3 read 1.
// - Byte 2 bits 0,2 enable outputs 6,7; bit 1 reads 1.
// - Cleared enable bit forces its output low/low despite the pin.
// - Bytes 3 and 4 reserved, reading zero.
// - Slave address 1101100 plus read/write bit.
// - General call address is not answered.
// - Byte 7 five-bit readback count, default eight.
module clock_buffer_smbus_regs
	import clock_buffer_regs_pkg::*;
#(
	parameter int         NUM_OUTPUTS     = 8,
	parameter logic [6:0] SLAVE_ADDR      = SLAVE_ADDRESS,
	parameter logic [7:0] VENDOR_REV_CODE = 8'h5A,   // Arbitrary value
	parameter logic [7:0] DEVICE_CODE     = 8'hA5    // Arbitrary value
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   resetn,
	input  wire logic                   clkEn,
	// Straps and power control
	input  wire logic                   powerDownN,
	input  wire logic                   freqSelectStrap,
	input  wire logic [1:0]             pllBandwidthStrap,
	input  wire logic [NUM_OUTPUTS-1:0] outEnPinN,
	// SMBus pins
	input  wire logic                   sclIn,
	input  wire logic                   sdaIn,
	output logic                        sdaOut,
	output logic                        sdaOe,
	// Controls to the clock path
	output logic [NUM_OUTPUTS-1:0]      diffClockOutputEn,
	output logic [1:0]                  pllMode
);

	generate
		if (NUM_OUTPUTS != 8) begin : g_bad_outputs
			$error("clock_buffer_smbus_regs supports exactly eight outputs");
		end
	endgenerate

	state_type q;
	state_type d;

	logic       sclRise;
	logic       sclFall;
	logic       startSeen;
	logic       stopSeen;
	logic       powerDown;
	logic       latchEvent;
	logic [7:0] txByte;
	logic [7:0] rxByte;

	function automatic logic [7:0] regRead(input state_type s, input logic [6:0] idx);
		logic [7:0] v;
		v = BYTE_ZERO;
		unique case (idx)
			REG_FREQ_PLL_MODE_CONTROL: v = {s.pllStrap, 2'h0, s.ctrl, s.freqStrap};
			REG_OUTPUT_ENABLE_LOW:     v = {s.oe[5:2], 1'b1, s.oe[1:0], 1'b1};
			REG_OUTPUT_ENABLE_HIGH:    v = {5'h00, s.oe[7], 1'b1, s.oe[6]};
			REG_VENDOR_REVISION:       v = VENDOR_REV_CODE;
			REG_DEVICE_IDENT:          v = DEVICE_CODE;
			REG_READBACK_COUNT:        v = {3'h0, s.rbCount};
			default:                   v = BYTE_ZERO;
		endcase
		return v;
	endfunction

	// Only writable fields are stored; everything else is dropped
	function automatic state_type regWrite(input state_type s, input logic [6:0] idx,
		input logic [7:0] data);
		state_type r;
		r = s;
		unique case (idx)
			REG_FREQ_PLL_MODE_CONTROL: r.ctrl = data[3:1];
			REG_OUTPUT_ENABLE_LOW:     r.oe[5:0] = {data[7:4], data[2:1]};
			REG_OUTPUT_ENABLE_HIGH:    r.oe[7:6] = {data[2], data[0]};
			REG_READBACK_COUNT:        r.rbCount = data[4:0];
			default:                   r = s;
		endcase
		return r;
	endfunction

	assign sclRise    = sclIn && !q.sclPrev;
	assign sclFall    = !sclIn && q.sclPrev;
	assign startSeen  = sclIn && q.sclPrev && q.sdaPrev && !sdaIn;
	assign stopSeen   = sclIn && q.sclPrev && !q.sdaPrev && sdaIn;
	assign powerDown  = q.latched && !powerDownN;
	assign latchEvent = powerDownN && !q.pgPrev && !q.latched;
	assign rxByte     = q.shift;
	assign txByte     = (q.block && !q.countSent) ? {3'h0, q.rbCount} : regRead(q, q.index);

	always_comb begin
		d = q;
		d.sclPrev = sclIn;
		d.sdaPrev = sdaIn;
		d.pgPrev  = powerDownN;
		// Straps caught on the first power-good rise only
		if (latchEvent) begin
			d.latched   = 1'b1;
			d.freqStrap = freqSelectStrap;
			d.pllStrap  = pllBandwidthStrap;
		end
		if (powerDown) begin
			// Registers untouched; bus released so the host sees no slave
			d.fsm   = ST_IDLE;
			d.sdaOe = 1'b0;
		end else if (stopSeen) begin
			d.fsm   = ST_IDLE;
			d.sdaOe = 1'b0;
		end else if (startSeen) begin
			d.fsm    = ST_RECV;
			d.phase  = PH_ADDR;
			d.bitCnt = 4'h0;
			d.sdaOe  = 1'b0;
		end else begin
			unique case (q.fsm)
				ST_IDLE: begin
					d.sdaOe = 1'b0;
				end
				ST_RECV: begin
					if (sclRise && q.bitCnt != BITS_PER_BYTE) begin
						d.shift  = {q.shift[6:0], sdaIn};
						d.bitCnt = q.bitCnt + 4'h1;
					end else if (sclFall && q.bitCnt == BITS_PER_BYTE) begin
						d.fsm   = ST_RACK;
						d.sdaOe = 1'b1;
						unique case (q.phase)
							PH_ADDR: begin
								// General call never matches a nonzero address
								if (rxByte[7:1] == SLAVE_ADDR) begin
									d.read  = rxByte[0];
									d.phase = rxByte[0] ? PH_DATA : PH_CMD;
								end else begin
									d.fsm   = ST_IDLE;
									d.sdaOe = 1'b0;
								end
							end
							PH_CMD: begin
								d.block     = !rxByte[CMD_BYTE_MODE];
								d.index     = rxByte[6:0];
								d.countSent = 1'b0;
								d.remain    = BYTE_MODE_CNT;
								d.phase     = d.block ? PH_COUNT : PH_DATA;
							end
							PH_COUNT: begin
								// Counts outside 1..32 are the host's fault; only the low six bits are kept
								d.remain = rxByte[5:0];
								d.phase  = PH_DATA;
							end
							PH_DATA: begin
								// Bytes past the count are still acked but not stored
								if (q.remain != 6'h00) begin
									d        = regWrite(d, q.index, rxByte);
									d.remain = q.remain - 6'h01;
								end
								d.index = q.index + 7'h01;
							end
							default: begin
								d.fsm   = ST_IDLE;
								d.sdaOe = 1'b0;
							end
						endcase
					end
				end
				ST_RACK: begin
					if (sclFall) begin
						d.bitCnt = 4'h0;
						if (q.read) begin
							d.fsm   = ST_SEND;
							d.shift = txByte;
							d.sdaOe = !txByte[7];
							if (q.block && !q.countSent) begin
								d.countSent = 1'b1;
							end else begin
								d.index = q.index + 7'h01;
							end
						end else begin
							d.fsm   = ST_RECV;
							d.sdaOe = 1'b0;
						end
					end
				end
				ST_SEND: begin
					if (sclFall) begin
						if (q.bitCnt == LAST_BIT) begin
							d.fsm   = ST_MACK;
							d.sdaOe = 1'b0;
						end else begin
							d.bitCnt = q.bitCnt + 4'h1;
							d.shift  = {q.shift[6:0], 1'b0};
							d.sdaOe  = !q.shift[6];
						end
					end
				end
				ST_MACK: begin
					// Host not-acknowledge ends the read; wait for stop
					if (sclRise) begin
						d.fsm = sdaIn ? ST_IDLE : ST_RACK;
					end
				end
				default: begin
					d.fsm   = ST_IDLE;
					d.sdaOe = 1'b0;
				end
			endcase
		end
		// Output gating: a cleared register bit overrides the enable pin
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			d.diffEn[i] = powerDownN && !outEnPinN[i] && d.oe[i];
		end
		// New mode takes effect now; system must warm reset before relying on it
		d.pllMode = d.ctrl[PLL_SW_ENABLE] ? d.ctrl[1:0] : d.pllStrap;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q           <= '0;
			q.fsm       <= ST_IDLE;
			q.phase     <= PH_ADDR;
			q.sclPrev   <= 1'b1;
			q.sdaPrev   <= 1'b1;
			q.ctrl      <= CTRL_RESET;
			q.oe        <= OUTPUT_EN_RESET;
			q.rbCount   <= READBACK_CNT_RESET;
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign sdaOut            = q.sdaLevel;
	assign sdaOe             = q.sdaOe;
	assign diffClockOutputEn = q.diffEn;
	assign pllMode           = q.pllMode;

	// Checks
	sequence s_addrByteDone;
		q.fsm == ST_RECV && q.phase == PH_ADDR && q.bitCnt == BITS_PER_BYTE && sclFall;
	endsequence

	sequence s_dataWrite;
		q.fsm == ST_RECV && q.phase == PH_DATA && q.bitCnt == BITS_PER_BYTE && sclFall
			&& q.remain != 6'h00 && !powerDown && !stopSeen && !startSeen;
	endsequence

	property p_pdRelease;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && powerDown |=> !sdaOe && q.oe == $past(q.oe);
	endproperty
	a_pdRelease: assert property (p_pdRelease) else $error("bus not released in power-down");

	property p_addrAck;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && !powerDown && !stopSeen && !startSeen ##0 s_addrByteDone
			|=> (sdaOe == (rxByte[7:1] == SLAVE_ADDR));
	endproperty
	a_addrAck: assert property (p_addrAck) else $error("address ack wrong");

	property p_blockIndex;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && q.fsm == ST_RECV && q.phase == PH_CMD && q.bitCnt == BITS_PER_BYTE && sclFall
			&& !powerDown && !stopSeen && !startSeen && !rxByte[CMD_BYTE_MODE]
			|=> q.index == $past(rxByte[6:0]) && q.block && q.phase == PH_COUNT;
	endproperty
	a_blockIndex: assert property (p_blockIndex) else $error("block start index wrong");

	property p_indexAdvance;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn ##0 s_dataWrite |=> q.index == $past(q.index) + 7'h01 && q.fsm == ST_RACK;
	endproperty
	a_indexAdvance: assert property (p_indexAdvance) else $error("index did not advance");

	property p_lowByteWrite;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn ##0 s_dataWrite ##0 q.index == REG_OUTPUT_ENABLE_LOW
			|=> q.oe[5:0] == {$past(rxByte[7:4]), $past(rxByte[2:1])};
	endproperty
	a_lowByteWrite: assert property (p_lowByteWrite) else $error("enable byte write wrong");

	property p_outputForce;
		@(posedge sys_clk) disable iff (!resetn)
		// Enable and gate come from the same edge, so judge both one cycle on
		clkEn ##1 !q.oe[0] |-> !diffClockOutputEn[0];
	endproperty
	a_outputForce: assert property (p_outputForce) else $error("output not forced off");

	property p_pllStrapMode;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn ##1 !q.ctrl[PLL_SW_ENABLE] |-> pllMode == q.pllStrap;
	endproperty
	a_pllStrapMode: assert property (p_pllStrapMode) else $error("strap PLL mode not used");

	property p_strapHeld;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && !latchEvent |=> $stable(q.freqStrap) && $stable(q.pllStrap);
	endproperty
	a_strapHeld: assert property (p_strapHeld) else $error("latched strap changed");

	property p_countFirst;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && q.fsm == ST_RACK && sclFall && q.read && q.block && !q.countSent
			&& !powerDown && !stopSeen && !startSeen
			|=> q.fsm == ST_SEND && q.shift == {3'h0, q.rbCount} && q.countSent;
	endproperty
	a_countFirst: assert property (p_countFirst) else $error("count byte not sent first");

	property p_readNack;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && q.fsm == ST_MACK && sclRise && sdaIn && !powerDown && !stopSeen && !startSeen
			|=> q.fsm == ST_IDLE ##1 !sdaOe;
	endproperty
	a_readNack: assert property (p_readNack) else $error("read continued after nack");

	property p_byteMode;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && q.fsm == ST_RECV && q.phase == PH_CMD && q.bitCnt == BITS_PER_BYTE && sclFall
			&& !powerDown && !stopSeen && !startSeen && rxByte[CMD_BYTE_MODE]
			|=> !q.block && q.phase == PH_DATA && q.remain == BYTE_MODE_CNT;
	endproperty
	a_byteMode: assert property (p_byteMode) else $error("byte mode command mishandled");

	// Reserved bytes must go out as zero whatever was written to them
	property p_reservedRead;
		@(posedge sys_clk) disable iff (!resetn)
		clkEn && q.fsm == ST_RACK && sclFall && q.read && (q.countSent || !q.block)
			&& (q.index == REG_RESERVED_CONTROL_A || q.index == REG_RESERVED_CONTROL_B)
			&& !powerDown && !stopSeen && !startSeen
			|=> q.fsm == ST_SEND && q.shift == BYTE_ZERO;
	endproperty
	a_reservedRead: assert property (p_reservedRead) else $error("reserved byte not zero");

	// Edge history is frozen too, so no false bus event after re-enable
	property p_freeze;
		@(posedge sys_clk) disable iff (!resetn)
		!clkEn |=> q == $past(q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

endmodule // clock_buffer_smbus_regs

//--- verification/smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
	// Clock
	input  wire logic sys_clk,
	// Bus wires
	input  wire logic sdaOe,
	output logic      scl,
	output wire logic sda
);
	logic hostLow;
	// Pull-up wins unless a party pulls low
	assign sda = !(hostLow || sdaOe);
	initial begin
		scl = 1'b1;
		hostLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Data moves one cycle after SCL falls, never on the same edge
	task automatic clockBit(input logic pull, output logic seen);
		tick(1);
		hostLow <= pull;
		tick(4);
		scl <= 1'b1;
		tick(2);
		#1 seen = sda;
		tick(2);
		scl <= 1'b0;
	endtask
	task automatic start();
		tick(1);
		hostLow <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		hostLow <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		tick(1);
		hostLow <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		hostLow <= 1'b0;
		tick(4);
	endtask
	task automatic writeByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clockBit(!d[i], s);
		end
		clockBit(1'b0, s);
		ack = !s;
	endtask
	task automatic readByte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clockBit(1'b0, s);
			d[i] = s;
		end
		clockBit(!last, s);
	endtask
endmodule // smbus_host_model

//--- verification/clock_buffer_smbus_regs_test.sv
`timescale 1ns/1ps
module clock_buffer_smbus_regs_test;
	import clock_buffer_regs_pkg::*;
	logic        sys_clk;
	logic        resetn;
	logic        clkEn;
	logic [7:0]  freezeExp;
	logic        powerDownN;
	logic        freqSelectStrap;
	logic [1:0]  pllBandwidthStrap;
	logic [7:0]  outEnPinN;
	logic        scl;
	wire logic   sda;
	logic        sdaOut;
	logic        sdaOe;
	logic [7:0]  diffClockOutputEn;
	logic [1:0]  pllMode;
	logic [7:0]  img [8];
	logic [15:0] lfsr;
	logic [7:0]  rnd;
	int          error_cnt;
	int          compares;
	int          cycles;

	clock_buffer_smbus_regs #(.VENDOR_REV_CODE(8'h3C), .DEVICE_CODE(8'hC3)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .powerDownN(powerDownN),
		.freqSelectStrap(freqSelectStrap), .pllBandwidthStrap(pllBandwidthStrap),
		.outEnPinN(outEnPinN), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.diffClockOutputEn(diffClockOutputEn), .pllMode(pllMode));
	smbus_host_model host (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));

	function automatic logic [15:0] nextLfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] storeMask(input logic [6:0] idx);
		case (idx)
			7'h00: return 8'h0E;
			7'h01: return 8'hF6;
			7'h02: return 8'h05;
			7'h07: return 8'h1F;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] expEn();
		logic [7:0] e;
		e = {img[2][2], img[2][0], img[1][7:4], img[1][2:1]};
		return powerDownN ? (e & ~outEnPinN) : 8'h00;
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [7:0] d, input logic [7:0] expAck);
		logic a;
		host.writeByte(d, a);
		check("ack", {7'h00, a}, expAck);
	endtask
	task automatic store(input logic [6:0] idx, input logic [7:0] d);
		img[idx] = (img[idx] & ~storeMask(idx)) | (d & storeMask(idx));
	endtask
	task automatic regWrite(input logic [6:0] idx, input logic [7:0] d);
		host.start();
		put({SLAVE_ADDRESS, 1'b0}, 8'h01);
		put({1'b1, idx}, 8'h01);
		put(d, 8'h01);
		host.stop();
		store(idx, d);
		check("enables", diffClockOutputEn, expEn());
		check("pll", {6'h00, pllMode}, {6'h00, img[0][3] ? img[0][2:1] : img[0][7:6]});
	endtask
	task automatic addrRead(input logic [7:0] cmd);
		host.start();
		put({SLAVE_ADDRESS, 1'b0}, 8'h01);
		put(cmd, 8'h01);
		host.start();
		put({SLAVE_ADDRESS, 1'b1}, 8'h01);
	endtask
	task automatic regRead(input logic [6:0] idx);
		logic [7:0] d;
		addrRead({1'b1, idx});
		host.readByte(1'b1, d);
		host.stop();
		check("byte read", d, img[idx]);
	endtask
	task automatic blockWrite(input logic [6:0] idx, input logic [7:0] vals [$]);
		logic [6:0] j;
		j = idx;
		host.start();
		put({SLAVE_ADDRESS, 1'b0}, 8'h01);
		put({1'b0, idx}, 8'h01);
		put(8'(vals.size()), 8'h01);
		foreach (vals[i]) begin
			put(vals[i], 8'h01);
			store(j, vals[i]);
			j++;
		end
		host.stop();
	endtask
	task automatic blockRead(input logic [6:0] idx);
		logic [7:0] d;
		logic [7:0] n;
		addrRead({1'b0, idx});
		host.readByte(1'b0, n);
		check("count", n, img[7]);
		for (int i = 0; i < int'(n); i++) begin
			host.readByte(i == int'(n) - 1, d);
			check("block read", d, img[idx + 7'(i)]);
		end
		host.stop();
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Ceiling is several times the expected run length
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		resetn = 1'b0;
		clkEn = 1'b1;
		powerDownN = 1'b0;
		lfsr = 16'h8F4E;
		lfsr = nextLfsr(lfsr);
		// Strap drawn from the three legal levels only
		freqSelectStrap = lfsr[0];
		pllBandwidthStrap = {lfsr[2] & lfsr[1], lfsr[1]};
		outEnPinN = 8'h00;
		error_cnt = 0;
		compares = 0;
		cycles = 0;
		img = '{8'h47, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h3C, 8'hC3, 8'h08};
		img[0] = {lfsr[2] & lfsr[1], lfsr[1], 2'b00, CTRL_RESET, lfsr[0]};
		host.tick(2);
		resetn <= 1'b1;
		host.tick(2);
		powerDownN <= 1'b1;
		host.tick(2);
		// Straps move after capture; readback must not follow
		freqSelectStrap <= !freqSelectStrap;
		pllBandwidthStrap <= (pllBandwidthStrap == 2'b11) ? 2'b00 : 2'b11;
		host.tick(2);
		check("enables", diffClockOutputEn, expEn());
		check("drive level", {7'h00, sdaOut}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			regRead(7'(i));
		end
		$display("reset values done");
		regWrite(7'h00, 8'hFF);
		regWrite(7'h03, 8'hFF);
		regWrite(7'h04, 8'hFF);
		regRead(7'h00);
		regRead(7'h03);
		for (int k = 0; k < 12; k++) begin
			lfsr = nextLfsr(lfsr);
			rnd = lfsr[15:8];
			outEnPinN <= lfsr[7:0] & 8'h11;
			regWrite({5'h00, lfsr[1:0]}, rnd);
			regRead({5'h00, lfsr[1:0]});
		end
		$display("random writes done");
		blockWrite(7'h00, '{8'h00, 8'h00, 8'hFF});
		blockWrite(7'h01, '{8'hA5});
		blockWrite(7'h07, '{8'h03});
		blockRead(7'h05);
		blockWrite(7'h07, '{8'h08});
		blockRead(7'h00);
		$display("block transfers done");
		host.start();
		put(8'h00, 8'h00);
		host.stop();
		// Frozen clock enable must hold the gates even as power-down arrives
		freezeExp = expEn();
		clkEn <= 1'b0;
		powerDownN <= 1'b0;
		host.tick(3);
		check("frozen enables", diffClockOutputEn, freezeExp);
		clkEn <= 1'b1;
		host.tick(3);
		check("enables", diffClockOutputEn, expEn());
		host.start();
		put({SLAVE_ADDRESS, 1'b0}, 8'h00);
		host.stop();
		powerDownN <= 1'b1;
		host.tick(3);
		regRead(7'h01);
		regRead(7'h00);
		$display("power-down done");
		tally_and_finish();
	end
endmodule // clock_buffer_smbus_regs_test
